// ---- hw/emb_map.vh ----
// Constants for the external memory bus pin block
`ifndef EMB_MAP_VH
`define EMB_MAP_VH
`define EMB_IADDR_W 24
`define EMB_XADDR_W 21
`define EMB_XADDR_TOP 20
`define EMB_XSPACE_MAX 24'h1fffff
`define EMB_RESET_INT 24'hff2080
`define EMB_RESET_EXT_FETCH 24'h1f2080
`define EMB_PH_CYCLES 3'h2
`define EMB_DATA_CYCLES 3'h4
`define EMB_CNT_ONE 3'h1
`define EMB_CNT_ZERO 3'h0
`define EMB_ADDR_LO 15:0
`define EMB_ZERO5 5'h00
`define EMB_ONES8 8'hff
`define EMB_BYTE_HI 15:8
`define EMB_BYTE_LO 7:0
`define EMB_UPPER_X 20:16
`define EMB_ZERO8 8'h00
`define EMB_ZERO16 16'h0000
`define EMB_ZERO21 21'h000000
`define EMB_REGIONS 4
`define EMB_REG_SEL 20:19
`endif

// ---- hw/emb_region_cfg.v ----
// Region decode: width and mux mode of the addressed external region
`include "emb_map.vh"
module emb_region_cfg (
   input wire [20:0] xaddr,
   input wire [3:0] region_wide,
   input wire [3:0] region_mux,
   output reg wide,
   output reg mux
);
   // Top two external address bits pick one of four regions
   always @* begin
      wide = region_wide[xaddr[`EMB_REG_SEL]];
      mux = region_mux[xaddr[`EMB_REG_SEL]];
   end
endmodule // emb_region_cfg

// ---- hw/emb_bus.v ----
// External memory bus pin sequencer with port sharing
//
// Contract
// RQ1 - In 16-bit multiplexed mode all sixteen lines carry address first, then data.
// RQ2 - In 8-bit multiplexed mode the upper lines hold address bits 8 to 15 all cycle.
// RQ3 - In 8-bit multiplexed mode the lower lines carry address 0 to 7, then data.
// RQ4 - In 16-bit demultiplexed mode all sixteen lines carry only data.
// RQ5 - In 8-bit demultiplexed mode the lower lines carry only data.
// RQ6 - In 8-bit demultiplexed mode the upper lines show the internal bus high byte.
// RQ7 - The upper external address lines stay valid through the whole cycle.
// RQ8 - Only the low 21 bits of the 24-bit address leave the device.
// RQ9 - Addresses up to 1fffff go external, the full 24-bit space is decoded.
// RQ10 - After reset the first fetch is at ff2080 internal or 1f2080 external.
// RQ11 - The address-valid strobe goes low only for external accesses.
// RQ12 - The strobe stays low through the cycle and rises when it ends. The code raises it one clock early, for the last of the four data clocks.
// RQ13 - Outside logic may latch the address and qualify chip selects on the strobe.
// RQ14 - Shared lines fall back to ports three and four outside bus cycles.
// RQ15 - The strobe pin doubles as port five bit zero.
// RQ16 - Width and mux mode follow the addressed region, access by access.
`include "emb_map.vh"
module emb_bus (
   input wire clk,
   input wire arst_n,
   input wire boot_external,
   input wire req,
   input wire [23:0] req_addr,
   input wire req_write,
   input wire [15:0] wdata,
   input wire [15:0] internal_bus,
   input wire [3:0] region_wide,
   input wire [3:0] region_mux,
   input wire [7:0] port_three_bits,
   input wire [7:0] port_four_bits,
   input wire port_five_bit_zero,
   input wire [15:0] shared_in,
   output reg [15:0] shared_out_q,
   output reg [15:0] shared_oe_q,
   output reg [4:0] upper_external_address_q,
   output reg [20:0] external_address_pins_q,
   output reg address_valid_n_q,
   output reg busy_q,
   output reg done_q,
   output reg internal_q,
   output reg [15:0] rdata_q,
   output reg [23:0] reset_fetch_q
);
   localparam S_IDLE = 3'b001;
   localparam S_ADDR = 3'b010;
   localparam S_DATA = 3'b100;
   reg [2:0] st_q;
   reg [2:0] cnt_q;
   reg [23:0] addr_q;
   reg wr_q;
   reg [15:0] wd_q;
   reg wide_q;
   reg mux_q;
   reg [15:0] sin1_q;
   reg [15:0] sin2_q;
   reg [7:0] p3a_q, p3b_q, p4a_q, p4b_q;
   reg p5a_q, p5b_q;
   reg boot_a_q, boot_b_q, boot_seen_q;
   wire wide;
   wire mux;
   // RQ16 region lookup
   emb_region_cfg u_cfg (
      .xaddr(req_addr[`EMB_XADDR_TOP:0]),
      .region_wide(region_wide),
      .region_mux(region_mux),
      .wide(wide),
      .mux(mux)
   );
   // RQ9 external range test
   function is_ext;
      input [23:0] a;
      begin
         is_ext = (a <= `EMB_XSPACE_MAX);
      end
   endfunction
   // Pins from outside the domain pass two flops
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sin1_q <= `EMB_ZERO16;
         sin2_q <= `EMB_ZERO16;
         p3a_q <= `EMB_ZERO8;
         p3b_q <= `EMB_ZERO8;
         p4a_q <= `EMB_ZERO8;
         p4b_q <= `EMB_ZERO8;
         p5a_q <= 1'b1;
         p5b_q <= 1'b1;
      end else begin
         sin1_q <= shared_in;
         sin2_q <= sin1_q;
         p3a_q <= port_three_bits;
         p3b_q <= p3a_q;
         p4a_q <= port_four_bits;
         p4b_q <= p4a_q;
         p5a_q <= port_five_bit_zero;
         p5b_q <= p5a_q;
      end
   end
   // Strap sync runs through reset so its level is settled at release
   always @(posedge clk) begin
      boot_a_q <= boot_external;
      boot_b_q <= boot_a_q;
   end
   // RQ10 boot strap caught once after release
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         boot_seen_q <= 1'b0;
         reset_fetch_q <= `EMB_RESET_INT;
      end else if (!boot_seen_q) begin
         boot_seen_q <= 1'b1;
         reset_fetch_q <= boot_b_q ? `EMB_RESET_EXT_FETCH : `EMB_RESET_INT;
      end
   end
   // Bus sequencer; two address clocks, four data clocks
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= S_IDLE;
         cnt_q <= `EMB_CNT_ZERO;
         addr_q <= `EMB_RESET_INT;
         wr_q <= 1'b0;
         wd_q <= `EMB_ZERO16;
         wide_q <= 1'b0;
         mux_q <= 1'b0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         internal_q <= 1'b0;
         rdata_q <= `EMB_ZERO16;
      end else begin
         done_q <= 1'b0;
         internal_q <= 1'b0;
         case (st_q)
            S_IDLE: begin
               // RQ11 internal access, no strobe
               if (req && !is_ext(req_addr)) begin
                  internal_q <= 1'b1;
               end else if (req) begin
                  addr_q <= req_addr;
                  wr_q <= req_write;
                  wd_q <= wdata;
                  wide_q <= wide;
                  mux_q <= mux;
                  busy_q <= 1'b1;
                  cnt_q <= `EMB_PH_CYCLES;
                  st_q <= S_ADDR;
               end
            end
            S_ADDR: begin
               if (cnt_q == `EMB_CNT_ONE) begin
                  // Data phase long enough for read data to clear the pin sync
                  cnt_q <= `EMB_DATA_CYCLES;
                  st_q <= S_DATA;
               end else begin
                  cnt_q <= cnt_q - `EMB_CNT_ONE;
               end
            end
            S_DATA: begin
               if (cnt_q == `EMB_CNT_ONE) begin
                  // Sync output now holds the lines of the first data clock
                  if (wide_q) begin
                     rdata_q <= sin2_q;
                  end else begin
                     rdata_q <= {`EMB_ZERO8, sin2_q[`EMB_BYTE_LO]};
                  end
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
                  cnt_q <= `EMB_CNT_ZERO;
                  st_q <= S_IDLE;
               end else begin
                  cnt_q <= cnt_q - `EMB_CNT_ONE;
               end
            end
            default: begin
               st_q <= S_IDLE;
            end
         endcase
      end
   end
   // Pin drive, registered so outputs come straight from flops
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         shared_out_q <= `EMB_ZERO16;
         shared_oe_q <= `EMB_ZERO16;
         upper_external_address_q <= `EMB_ZERO5;
         external_address_pins_q <= `EMB_ZERO21;
         address_valid_n_q <= 1'b1;
      end else if (st_q == S_IDLE) begin
         // RQ14 ports own the shared lines between cycles
         shared_out_q <= {p4b_q, p3b_q};
         shared_oe_q <= {16{1'b1}};
         // RQ15 strobe pin works as port five bit zero
         address_valid_n_q <= p5b_q;
         // Hold last address so latches see no glitch
         external_address_pins_q <= external_address_pins_q;
      end else begin
         // RQ12 strobe low through the address clocks and first three data clocks, high again for the last data clock
         address_valid_n_q <= (st_q == S_DATA) && (cnt_q == `EMB_CNT_ONE);
         // RQ7 RQ8 low 21 bits held all cycle
         external_address_pins_q <= addr_q[`EMB_XADDR_TOP:0];
         upper_external_address_q <= addr_q[`EMB_UPPER_X];
         if (st_q == S_ADDR && mux_q) begin
            // RQ1 RQ3 address phase on shared lines
            shared_out_q <= addr_q[`EMB_ADDR_LO];
            shared_oe_q <= {16{1'b1}};
         end else begin
            // RQ4 RQ5 data; reads release the data lanes
            shared_out_q[`EMB_BYTE_LO] <= wd_q[`EMB_BYTE_LO];
            shared_oe_q[`EMB_BYTE_LO] <= {8{wr_q}};
            if (wide_q) begin
               shared_out_q[`EMB_BYTE_HI] <= wd_q[`EMB_BYTE_HI];
               shared_oe_q[`EMB_BYTE_HI] <= {8{wr_q}};
            end else if (mux_q) begin
               // RQ2 upper address byte held
               shared_out_q[`EMB_BYTE_HI] <= addr_q[`EMB_BYTE_HI];
               shared_oe_q[`EMB_BYTE_HI] <= `EMB_ONES8;
            end else begin
               // RQ6 internal bus high byte shown
               shared_out_q[`EMB_BYTE_HI] <= internal_bus[`EMB_BYTE_HI];
               shared_oe_q[`EMB_BYTE_HI] <= `EMB_ONES8;
            end
         end
      end
   end
endmodule // emb_bus

// ---- test/emb_bus_monitor.sv ----
// Checker for the external bus pin sequencer
module emb_bus_monitor (
   input wire clk,
   input wire arst_n,
   input wire req,
   input wire [23:0] req_addr,
   input wire req_write,
   input wire [15:0] wdata,
   input wire [15:0] internal_bus,
   input wire [3:0] region_wide,
   input wire [3:0] region_mux,
   input wire [7:0] port_three_bits,
   input wire [7:0] port_four_bits,
   input wire [15:0] shared_out_q,
   input wire [15:0] shared_oe_q,
   input wire [4:0] upper_external_address_q,
   input wire [20:0] external_address_pins_q,
   input wire address_valid_n_q,
   input wire busy_q,
   input wire done_q,
   input wire internal_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   wire take = req && !busy_q;
   wire ext = take && req_addr <= 24'h1fffff;
   wire wide = region_wide[req_addr[20:19]];
   wire mux = region_mux[req_addr[20:19]];
   logic [23:0] a_q;
   logic [15:0] d_q;
   // Keep the request so checks outlive it
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         a_q <= 24'h000000;
         d_q <= 16'h0000;
      end else if (take) begin
         a_q <= req_addr;
         d_q <= wdata;
      end
   end
   a_ext_done_delay: assert property (ext |-> ##7 done_q) else $error("late done");
   a_int_no_strobe: assert property (take && !ext |=> internal_q && address_valid_n_q)
      else $error("strobe on internal");
   a_strobe_low_cycle: assert property (ext |=> ##1 (!address_valid_n_q) [*5] ##1
      address_valid_n_q) else $error("strobe span");
   a_upper_addr_hold: assert property (ext |=> ##1
      (upper_external_address_q == a_q[20:16] && external_address_pins_q == a_q[20:0]) [*6])
      else $error("address pins");
   a_mux16_lines: assert property (ext && wide && mux && req_write |=> ##1
      (shared_out_q == a_q[15:0] && shared_oe_q == 16'hffff) [*2] ##1
      (shared_out_q == d_q && shared_oe_q == 16'hffff) [*4]) else $error("mux16 lines");
   a_mux8_upper: assert property (ext && !wide && mux |=> ##1
      (shared_out_q[15:8] == a_q[15:8] && shared_oe_q[15:8] == 8'hff) [*6])
      else $error("mux8 upper");
   a_mux8_lower: assert property (ext && !wide && mux && req_write |=> ##1
      (shared_out_q[7:0] == a_q[7:0]) [*2] ##1 (shared_out_q[7:0] == d_q[7:0]) [*4])
      else $error("mux8 low");
   a_demux16_data: assert property (ext && wide && !mux && req_write |=> ##1
      (shared_out_q == d_q && shared_oe_q == 16'hffff) [*6]) else $error("demux16 data");
   a_demux8_lower: assert property (ext && !wide && !mux && !req_write |=> ##1
      (shared_oe_q[7:0] == 8'h00) [*6]) else $error("demux8 low");
   a_demux8_upper: assert property (ext && !wide && !mux |=> ##1
      (shared_oe_q[15:8] == 8'hff && shared_out_q[15:8] == $past(internal_bus[15:8])) [*6])
      else $error("demux8 upper");
   a_idle_port_lines: assert property ((!busy_q && address_valid_n_q) [*4] |->
      shared_out_q == {port_four_bits, port_three_bits}) else $error("idle lines");
endmodule // emb_bus_monitor
bind emb_bus emb_bus_monitor mon_u (.clk, .arst_n, .req, .req_addr, .req_write, .wdata,
   .internal_bus, .region_wide, .region_mux, .port_three_bits, .port_four_bits, .shared_out_q,
   .shared_oe_q, .upper_external_address_q, .external_address_pins_q, .address_valid_n_q,
   .busy_q, .done_q, .internal_q);

// ---- test/emb_mem_model.sv ----
// External memory behind an address latch
module emb_mem_model (
   input wire clk,
   input wire address_valid_n,
   input wire [20:0] addr_pins,
   input wire [15:0] lines_oe,
   output wire [15:0] lines_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic alt_q = 1'b0;
   // Released lines toggle so stale data never reads back
   always @(posedge clk) alt_q <= ~alt_q;
   assign lines_in = (!address_valid_n && lines_oe[7:0] == 8'h00) ?
      {addr_pins[7:0] ^ 8'h3c, addr_pins[7:0]} : {16{alt_q}};
endmodule // emb_mem_model

// ---- test/emb_bus_tb_top.sv ----
// Self-checking bench for the external bus pin sequencer
module emb_bus_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic boot_external = 1'b0;
   logic req = 1'b0;
   logic req_write = 1'b0;
   logic [23:0] req_addr = 24'h000000;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] internal_bus = 16'hc35a;
   logic [3:0] region_wide = 4'h5;
   logic [3:0] region_mux = 4'h3;
   logic [7:0] port_three_bits = 8'h96;
   logic [7:0] port_four_bits = 8'h69;
   logic port_five_bit_zero = 1'b1;
   wire [15:0] shared_in, shared_out_q, shared_oe_q, rdata_q;
   wire [4:0] upper_external_address_q;
   wire [20:0] external_address_pins_q;
   wire [23:0] reset_fetch_q;
   wire address_valid_n_q, busy_q, done_q, internal_q;
   int n_fail = 0;
   int n_compared = 0;
   emb_bus dut_u (.clk, .arst_n, .boot_external, .req, .req_addr, .req_write, .wdata,
      .internal_bus, .region_wide, .region_mux, .port_three_bits, .port_four_bits,
      .port_five_bit_zero, .shared_in, .shared_out_q, .shared_oe_q, .upper_external_address_q,
      .external_address_pins_q, .address_valid_n_q, .busy_q, .done_q, .internal_q, .rdata_q,
      .reset_fetch_q);
   emb_mem_model mem_u (.clk, .address_valid_n(address_valid_n_q),
      .addr_pins(external_address_pins_q), .lines_oe(shared_oe_q), .lines_in(shared_in));
   initial forever #4 clk = ~clk;
   task automatic print_verdict;
      if (n_fail == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One access; a hang shows as a failed handshake
   task automatic access(input logic [23:0] a, input logic w, input logic [15:0] d,
      output logic si);
      int n;
      @(posedge clk);
      req <= 1'b1;
      req_addr <= a;
      req_write <= w;
      wdata <= d;
      @(posedge clk);
      req <= 1'b0;
      for (n = 0; n < 12 && done_q !== 1'b1 && internal_q !== 1'b1; n++) @(posedge clk);
      si = (internal_q === 1'b1);
      check("handshake", 24'h000001, {23'h000000, n < 12});
   endtask
   // Reset with the strap set, then the fetch address
   task automatic t_boot(input logic ext, input logic [23:0] exp);
      @(posedge clk);
      arst_n <= 1'b0;
      boot_external <= ext;
      repeat (11) @(posedge clk);
      check("oe_in_reset", 24'h000000, {8'h00, shared_oe_q});
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
      check("reset_fetch", exp, reset_fetch_q);
   endtask
   // Write then read in every width and mode, switching per access
   task automatic t_modes;
      logic [23:0] a;
      logic [15:0] exp;
      logic si;
      for (int r = 0; r < 4; r++) begin
         a = {3'h0, r[1:0], 19'h02a5b};
         // Fresh high byte each pass so a stale copy shows
         internal_bus <= {8'hc3 ^ r[7:0], 8'h5a};
         access(a, 1'b1, 16'hbeef ^ {r[7:0], 8'h00}, si);
         access(a, 1'b0, 16'h0000, si);
         exp = {a[7:0] ^ 8'h3c, a[7:0]};
         if (!region_wide[r]) exp[15:8] = 8'h00;
         check("read_data", {8'h00, exp}, {8'h00, rdata_q});
         check("went_external", 24'h000000, {23'h000000, si});
      end
   endtask
   // Split between external and internal space
   task automatic t_space;
      logic si;
      access(24'h1fffff, 1'b0, 16'h0000, si);
      check("top_external", 24'h000000, {23'h000000, si});
      check("top_read", 24'h0000ff, {8'h00, rdata_q});
      access(24'h200000, 1'b1, 16'h1234, si);
      check("first_internal", 24'h000001, {23'h000000, si});
      access(24'hff2080, 1'b0, 16'h0000, si);
      check("top_internal", 24'h000001, {23'h000000, si});
   endtask
   // Idle strobe pin follows the port bit it shares
   task automatic t_port;
      port_five_bit_zero <= 1'b0;
      repeat (4) @(posedge clk);
      check("port_pin_low", 24'h000000, {23'h000000, address_valid_n_q});
      port_five_bit_zero <= 1'b1;
      repeat (4) @(posedge clk);
      check("port_pin_high", 24'h000001, {23'h000000, address_valid_n_q});
   endtask
   // Watchdog well past the expected run
   initial begin
      #100000;
      n_fail++;
      print_verdict;
   end
   initial begin
      t_boot(1'b0, 24'hff2080);
      t_modes;
      t_space;
      t_port;
      t_boot(1'b1, 24'h1f2080);
      t_modes;
      print_verdict;
   end
endmodule // emb_bus_tb_top
